// >>> design/hblc_link_ctrl.sv
// packet framer and bit-oriented code controller for the facility data link
`timescale 1ns/1ps
// Operation
// - seven or more ones in a row set the latched abort flag.
// - closing flag with bad frame check sets the latched check-error flag.
// - storing a byte into a full receive FIFO sets the latched overflow flag.
// - a complete checked packet sets the latched good-message flag.
// - empty bit high exactly while receive FIFO is empty.
// - head byte marked when it closes a clean packet with correct check.
// - head byte marked when it closes any packet.
// - head byte marked when it opens a packet.
// - receive latched flags clear when the receive info register is read.
// - latched code-seen bit set on detection, cleared by reading it.
// - live code-seen bit follows current detection of a repeating code.
// - received code reported with first bit in bit 0.
// - code field holds last verified code, all ones after reset.
// - reading the receive FIFO port returns next byte, bit 7 most significant.
// - transmit FIFO empty mid-packet sends abort and sets underrun.
// - underrun flag clears when transmit info register is read.
// - rising edge of send bit starts sending the programmed code.
// - source select picks external link pin at 0, controller at 1.
// - transmitted code goes out bit 0 first, bit 5 last.
// - each write to transmit FIFO port queues one byte while the FIFO is not full.
// - receive FIFO holds 64 bytes; half-full raised beyond halfway.
module hblc_link_ctrl
  import hblc_pkg::*;
#(
  parameter int RX_DEPTH = 64,
  parameter int TX_DEPTH = 64,
  parameter int BIT_DIV = 64,
  parameter int CODE_VERIFY = 3
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // link pins
  input wire logic rx_link_data,
  input wire logic ext_link_input,
  output logic tx_link_data,
  // status
  output logic rx_half_full
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int DW = $clog2(BIT_DIV);

  // ==========================================================
  // pin synchronisers and bit-rate divider
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [DW-1:0] div_reg;
  logic tick_reg;
  logic rx_bit;
  logic ext_bit;
  assign rx_bit = pin_sync_reg[0];
  assign ext_bit = pin_sync_reg[1];

  // two stages on both pins
  always_ff @(posedge sys_clk)
  begin
    pin_meta_reg <= {ext_link_input, rx_link_data};
    pin_sync_reg <= pin_meta_reg;
  end

  // one-cycle bit enable
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (div_reg == DW'(BIT_DIV - 1));
      div_reg <= (div_reg == DW'(BIT_DIV - 1)) ? '0 : div_reg + 1'b1;
    end
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  // ==========================================================
  // register access decode
  logic rd_rx_info, rd_rx_code, rd_rx_fifo, rd_tx_info;
  logic wr_tx_code, wr_tx_fifo, wr_tx_last;
  assign rd_rx_info = reg_rd && (reg_addr == ADDR_RX_INFO);
  assign rd_rx_code = reg_rd && (reg_addr == ADDR_RX_CODE);
  assign rd_rx_fifo = reg_rd && (reg_addr == ADDR_RX_FIFO);
  assign rd_tx_info = reg_rd && (reg_addr == ADDR_TX_INFO);
  assign wr_tx_code = reg_wr && (reg_addr == ADDR_TX_CODE);
  assign wr_tx_fifo = reg_wr && (reg_addr == ADDR_TX_FIFO);
  assign wr_tx_last = reg_wr && (reg_addr == ADDR_TX_LAST);

  // ==========================================================
  // receive deframer
  logic [2:0] rx_ones_reg;
  logic [2:0] rx_bits_reg;
  logic [7:0] rx_sr_reg;
  logic [15:0] rx_crc_reg;
  logic [15:0] rx_crc_byte_reg;
  logic rx_in_frame_reg, rx_frame_ovr_reg;
  logic hold_valid_reg, hold_first_reg;
  logic [7:0] hold_byte_reg;
  logic ev_data, ev_flag, ev_abort, byte_done, rx_wr, rx_full, rx_empty;
  logic [15:0] rx_crc_next;
  hblc_rx_entry_type rx_wr_entry;

  assign ev_data = tick_reg && (rx_ones_reg < ONES_STUFF);
  assign ev_flag = tick_reg && !rx_bit && (rx_ones_reg == ONES_FLAG);
  assign ev_abort = tick_reg && rx_bit && (rx_ones_reg == ONES_FLAG);
  assign byte_done = ev_data && rx_in_frame_reg && (rx_bits_reg == BYTE_LAST);
  assign rx_crc_next = crc_step(rx_crc_reg, rx_bit);
  assign rx_wr = hold_valid_reg && (byte_done || (rx_in_frame_reg && (ev_flag || ev_abort)));

  // entry leaving the one-byte hold; closing marks known only at the flag or abort
  always_comb
  begin
    rx_wr_entry.first = hold_first_reg;
    rx_wr_entry.last = !byte_done;
    rx_wr_entry.good = ev_flag && (rx_crc_byte_reg == CRC_GOOD) && !rx_frame_ovr_reg;
    rx_wr_entry.data = hold_byte_reg;
  end

  // ones run, zero removal and byte assembly, first bit into bit 0
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rx_ones_reg <= '0;
      rx_bits_reg <= '0;
      rx_sr_reg <= '0;
      rx_crc_reg <= CRC_INIT;
      rx_crc_byte_reg <= CRC_INIT;
      rx_in_frame_reg <= 1'b0;
      rx_frame_ovr_reg <= 1'b0;
      hold_valid_reg <= 1'b0;
      hold_first_reg <= 1'b0;
      hold_byte_reg <= '0;
    end
    else if (tick_reg)
    begin
      rx_ones_reg <= !rx_bit ? 3'd0 : (rx_ones_reg == ONES_MAX) ? ONES_MAX : rx_ones_reg + 1'b1;
      if (ev_flag)
      begin
        rx_in_frame_reg <= 1'b1;
        rx_frame_ovr_reg <= 1'b0;
        rx_bits_reg <= '0;
        rx_crc_reg <= CRC_INIT;
        hold_valid_reg <= 1'b0;
        hold_first_reg <= 1'b1;
      end
      else if (ev_abort)
      begin
        rx_in_frame_reg <= 1'b0;
        hold_valid_reg <= 1'b0;
      end
      else if (ev_data && rx_in_frame_reg)
      begin
        rx_sr_reg <= {rx_bit, rx_sr_reg[7:1]};
        rx_bits_reg <= rx_bits_reg + 1'b1;
        rx_crc_reg <= rx_crc_next;
        if (byte_done)
        begin
          rx_crc_byte_reg <= rx_crc_next;
          hold_byte_reg <= {rx_bit, rx_sr_reg[7:1]};
          hold_valid_reg <= 1'b1;
          hold_first_reg <= !hold_valid_reg && hold_first_reg;
          if (rx_wr && rx_full)
            rx_frame_ovr_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // receive FIFO
  hblc_rx_entry_type rx_mem [RX_DEPTH];
  logic [RAW-1:0] rx_wp_reg, rx_rp_reg;
  logic [RAW:0] rx_cnt_reg;
  logic rx_pop, rx_push;
  hblc_rx_entry_type rx_head;
  assign rx_full = (rx_cnt_reg == (RAW+1)'(RX_DEPTH));
  assign rx_empty = (rx_cnt_reg == '0);
  assign rx_push = rx_wr && !rx_full;
  assign rx_pop = rd_rx_fifo && !rx_empty;
  assign rx_head = rx_mem[rx_rp_reg];

  always_ff @(posedge sys_clk)
  begin
    if (rx_push)
      rx_mem[rx_wp_reg] <= rx_wr_entry;
  end

  // pointers, fill level and half-full marker
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
      rx_half_full <= 1'b0;
    end
    else
    begin
      rx_wp_reg <= rx_push ? rx_wp_reg + 1'b1 : rx_wp_reg;
      rx_rp_reg <= rx_pop ? rx_rp_reg + 1'b1 : rx_rp_reg;
      rx_cnt_reg <= rx_cnt_reg + (RAW+1)'(rx_push) - (RAW+1)'(rx_pop);
      rx_half_full <= (rx_cnt_reg > (RAW+1)'(RX_DEPTH / 2));
    end
  end

  // ==========================================================
  // receive latched flags, set beats the clearing read
  logic abort_reg, crc_err_reg, ovr_reg, good_reg;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      abort_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      ovr_reg <= 1'b0;
      good_reg <= 1'b0;
    end
    else
    begin
      abort_reg <= ev_abort || (abort_reg && !rd_rx_info);
      crc_err_reg <= (ev_flag && hold_valid_reg && rx_in_frame_reg
                      && (rx_crc_byte_reg != CRC_GOOD)) || (crc_err_reg && !rd_rx_info);
      ovr_reg <= (rx_wr && rx_full) || (ovr_reg && !rd_rx_info);
      // a packet that lost bytes to overflow is not a valid message
      good_reg <= (ev_flag && hold_valid_reg && rx_in_frame_reg && !rx_frame_ovr_reg
                   && !rx_full && (rx_crc_byte_reg == CRC_GOOD))
                  || (good_reg && !rd_rx_info);
    end
  end

  // ==========================================================
  // code receiver: eight ones, zero, six code bits, zero
  logic [15:0] cw_reg;
  logic [15:0] cw_now;
  logic [5:0] cand_reg, code_reg;
  logic [4:0] phase_reg;
  logic [3:0] match_reg;
  logic live_reg, latch_reg, cw_hit;
  assign cw_now = {rx_bit, cw_reg[15:1]};
  assign cw_hit = (cw_now[7:0] == ONES_BYTE) && !cw_now[8] && !cw_now[15];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cw_reg <= '0;
      cand_reg <= CODE_RESET;
      code_reg <= CODE_RESET;
      phase_reg <= '0;
      match_reg <= '0;
      live_reg <= 1'b0;
      latch_reg <= 1'b0;
    end
    else
    begin
      if (tick_reg)
      begin
        cw_reg <= cw_now;
        if (cw_hit)
        begin
          phase_reg <= '0;
          cand_reg <= cw_now[14:9];
          if (cw_now[14:9] != cand_reg)
            match_reg <= 4'd1;
          else if (match_reg != 4'(CODE_VERIFY))
            match_reg <= match_reg + 1'b1;
          if ((cw_now[14:9] == cand_reg) && (match_reg + 1'b1 >= 4'(CODE_VERIFY)))
          begin
            code_reg <= cand_reg;
            live_reg <= 1'b1;
          end
        end
        else if (phase_reg == CODE_PERIOD - 1'b1)
        begin
          match_reg <= '0;
          live_reg <= 1'b0;
          phase_reg <= '0;
        end
        else
          phase_reg <= phase_reg + 1'b1;
      end
      latch_reg <= (!live_reg && tick_reg && cw_hit && (cw_now[14:9] == cand_reg)
                    && (match_reg + 1'b1 >= 4'(CODE_VERIFY)))
                   || (latch_reg && !rd_rx_code);
    end
  end

  // ==========================================================
  // transmit FIFO
  hblc_tx_entry_type tx_mem [TX_DEPTH];
  logic [TAW-1:0] tx_wp_reg, tx_rp_reg;
  logic [TAW:0] tx_cnt_reg;
  logic tx_full, tx_empty, tx_push, tx_pop;
  hblc_tx_entry_type tx_head;
  assign tx_full = (tx_cnt_reg == (TAW+1)'(TX_DEPTH));
  assign tx_empty = (tx_cnt_reg == '0);
  assign tx_push = (wr_tx_fifo || wr_tx_last) && !tx_full;
  assign tx_head = tx_mem[tx_rp_reg];

  always_ff @(posedge sys_clk)
  begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= '{eom: wr_tx_last, data: reg_wdata};
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end
    else
    begin
      tx_wp_reg <= tx_push ? tx_wp_reg + 1'b1 : tx_wp_reg;
      tx_rp_reg <= tx_pop ? tx_rp_reg + 1'b1 : tx_rp_reg;
      tx_cnt_reg <= tx_cnt_reg + (TAW+1)'(tx_push) - (TAW+1)'(tx_pop);
    end
  end

  // ==========================================================
  // code control register and send edge
  logic [7:0] txc_reg;
  logic code_req_reg, code_start;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      txc_reg <= TXC_RESET;
      code_req_reg <= 1'b0;
    end
    else
    begin
      if (wr_tx_code)
        txc_reg <= reg_wdata;
      code_req_reg <= (wr_tx_code && reg_wdata[TXC_SEND] && !txc_reg[TXC_SEND])
                      || (code_req_reg && !code_start);
    end
  end

  // ==========================================================
  // transmit framer: next byte choice at each byte boundary
  hblc_tx_state_type tx_state_reg, tx_state_next;
  logic [7:0] tx_sr_reg, tx_byte_next;
  logic [2:0] tx_left_reg, tx_ones_reg;
  logic [15:0] tx_crc_reg, tx_crc_upd;
  logic tx_stuff_reg, tx_stuff_next, tx_eom_reg, tx_bit_reg, starve, tx_insert, tx_load;
  assign tx_insert = (tx_ones_reg == ONES_STUFF);
  assign tx_load = tick_reg && !tx_insert && (tx_left_reg == '0);
  assign tx_crc_upd = (tx_state_reg == TX_DATA) ? crc_step(tx_crc_reg, tx_sr_reg[0]) : tx_crc_reg;

  always_comb
  begin
    tx_state_next = TX_IDLE;
    tx_byte_next = FLAG_BYTE;
    tx_stuff_next = 1'b0;
    tx_pop = 1'b0;
    starve = 1'b0;
    code_start = 1'b0;
    case (tx_state_reg)
      TX_CODE_HI:
      begin
        tx_state_next = TX_CODE_LO;
        tx_byte_next = {1'b0, txc_reg[5:0], 1'b0};
      end
      TX_DATA:
        if (tx_eom_reg)
        begin
          tx_state_next = TX_FCS_LO;
          tx_byte_next = ~tx_crc_upd[7:0];
          tx_stuff_next = 1'b1;
        end
        else if (!tx_empty)
        begin
          tx_state_next = TX_DATA;
          tx_byte_next = tx_head.data;
          tx_stuff_next = 1'b1;
          tx_pop = tx_load;
        end
        else
        begin
          tx_state_next = TX_ABORT;
          tx_byte_next = ONES_BYTE;
          starve = tx_load;
        end
      TX_FCS_LO:
      begin
        tx_state_next = TX_FCS_HI;
        tx_byte_next = ~tx_crc_reg[15:8];
        tx_stuff_next = 1'b1;
      end
      default:
        if (code_req_reg || (tx_state_reg == TX_CODE_LO && txc_reg[TXC_SEND]))
        begin
          tx_state_next = TX_CODE_HI;
          tx_byte_next = ONES_BYTE;
          code_start = tx_load;
        end
        else if (!tx_empty && tx_state_reg == TX_IDLE) // a flag always separates packets
        begin
          tx_state_next = TX_DATA;
          tx_byte_next = tx_head.data;
          tx_stuff_next = 1'b1;
          tx_pop = tx_load;
        end
    endcase
  end

  // serializer with zero insertion after five ones, bit 0 first
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tx_state_reg <= TX_IDLE;
      tx_sr_reg <= FLAG_BYTE;
      tx_left_reg <= BYTE_LAST;
      tx_ones_reg <= '0;
      tx_crc_reg <= CRC_INIT;
      tx_stuff_reg <= 1'b0;
      tx_eom_reg <= 1'b0;
      tx_bit_reg <= 1'b1;
    end
    else if (tick_reg)
    begin
      if (tx_insert)
      begin
        tx_bit_reg <= 1'b0;
        tx_ones_reg <= '0;
      end
      else
      begin
        tx_bit_reg <= tx_sr_reg[0];
        tx_ones_reg <= (tx_stuff_reg && tx_sr_reg[0]) ? tx_ones_reg + 1'b1 : 3'd0;
        tx_crc_reg <= tx_crc_upd;
        tx_sr_reg <= tx_sr_reg >> 1;
        tx_left_reg <= tx_left_reg - 1'b1;
        if (tx_left_reg == '0)
        begin
          tx_state_reg <= tx_state_next;
          tx_sr_reg <= tx_byte_next;
          tx_left_reg <= BYTE_LAST;
          tx_stuff_reg <= tx_stuff_next;
          tx_eom_reg <= tx_pop && tx_head.eom;
          if (tx_state_next == TX_DATA && tx_state_reg != TX_DATA)
            tx_crc_reg <= CRC_INIT;
        end
      end
    end
  end

  // ==========================================================
  // underrun flag and link output select
  logic starve_reg;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      starve_reg <= 1'b0;
      tx_link_data <= 1'b1;
    end
    else
    begin
      starve_reg <= starve || (starve_reg && !rd_tx_info);
      tx_link_data <= txc_reg[TXC_SRC] ? tx_bit_reg : ext_bit;
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_RX_INFO)
        reg_rdata <= {abort_reg, crc_err_reg, ovr_reg, good_reg, rx_empty,
                      !rx_empty && rx_head.good, !rx_empty && rx_head.last,
                      !rx_empty && rx_head.first};
      else if (reg_addr == ADDR_RX_CODE)
        reg_rdata <= {latch_reg, live_reg, code_reg};
      else if (reg_addr == ADDR_RX_FIFO)
        reg_rdata <= rx_empty ? 8'h00 : rx_head.data;
      else if (reg_addr == ADDR_TX_INFO)
        reg_rdata <= {5'h00, tx_empty, tx_full, starve_reg};
      else if (reg_addr == ADDR_TX_CODE)
        reg_rdata <= txc_reg;
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule // hblc_link_ctrl

// >>> inc/hblc_pkg.sv
// shared constants, carriers and states of the packet and code link controller
package hblc_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_RX_INFO = 8'h03;
  localparam logic [7:0] ADDR_RX_CODE = 8'h04;
  localparam logic [7:0] ADDR_RX_FIFO = 8'h05;
  localparam logic [7:0] ADDR_TX_INFO = 8'h06;
  localparam logic [7:0] ADDR_TX_CODE = 8'h07;
  localparam logic [7:0] ADDR_TX_FIFO = 8'h08;
  localparam logic [7:0] ADDR_TX_LAST = 8'h09;
  // ==========================================================
  // field positions
  localparam int RXI_ABORT = 7;
  localparam int RXI_CRC = 6;
  localparam int RXI_OVR = 5;
  localparam int RXI_GOOD = 4;
  localparam int RXI_EMPTY = 3;
  localparam int RXI_POK = 2;
  localparam int RXI_CLOSE = 1;
  localparam int RXI_OPEN = 0;
  localparam int RXC_LATCH = 7;
  localparam int RXC_LIVE = 6;
  localparam int TXI_EMPTY = 2;
  localparam int TXI_FULL = 1;
  localparam int TXI_STARVE = 0;
  localparam int TXC_SEND = 7;
  localparam int TXC_SRC = 6;
  // ==========================================================
  // reset values and line constants
  localparam logic [5:0] CODE_RESET = 6'h3F;
  localparam logic [7:0] TXC_RESET = 8'h00;
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] ONES_BYTE = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [2:0] ONES_STUFF = 3'd5;
  localparam logic [2:0] ONES_FLAG = 3'd6;
  localparam logic [2:0] ONES_MAX = 3'd7;
  localparam logic [2:0] BYTE_LAST = 3'd7;
  localparam logic [4:0] CODE_PERIOD = 5'd16;
  // ==========================================================
  // carriers and states
  typedef struct packed {
    logic first;
    logic last;
    logic good;
    logic [7:0] data;
  } hblc_rx_entry_type;
  typedef struct packed {
    logic eom;
    logic [7:0] data;
  } hblc_tx_entry_type;
  typedef enum logic [2:0] {
    TX_IDLE, TX_DATA, TX_FCS_LO, TX_FCS_HI, TX_ABORT, TX_CODE_HI, TX_CODE_LO
  } hblc_tx_state_type;
endpackage

// >>> verif/hblc_far_end.sv
// far terminal model that echoes the outgoing link and can corrupt one bit
`timescale 1ns/1ps
module hblc_far_end
  import hblc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link pins
  input wire logic tx_link_data,
  input wire logic flip,
  output logic rx_link_data
);
  // ==========================================================
  // loop back
  // echo each line bit one clock later, inverted while flip is high
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rx_link_data <= 1'b1;
    else
      rx_link_data <= tx_link_data ^ flip;
  end
endmodule // hblc_far_end

// >>> verif/hblc_link_ctrl_sva.sv
// concurrent checks on the register port and link pins of the link controller
`timescale 1ns/1ps
module hblc_link_ctrl_sva
  import hblc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // link pins and status
  input wire logic rx_link_data,
  input wire logic ext_link_input,
  input wire logic tx_link_data,
  input wire logic rx_half_full
);
  // ==========================================================
  // helper decode and shadow state
  logic rd_rxi;
  logic rd_txi;
  logic rd_txc;
  logic ext_reg;
  logic [7:0] txc_reg;
  logic [2:0] pass_cnt_reg;
  // read strobes per register
  assign rd_rxi = reg_rd && reg_addr == ADDR_RX_INFO;
  assign rd_txi = reg_rd && reg_addr == ADDR_TX_INFO;
  assign rd_txc = reg_rd && reg_addr == ADDR_TX_CODE;
  // shadow of the code control register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      txc_reg <= TXC_RESET;
    else if (reg_wr && reg_addr == ADDR_TX_CODE)
      txc_reg <= reg_wdata;
  end
  // cycles with pin source chosen and pin steady
  always_ff @(posedge sys_clk)
  begin
    ext_reg <= ext_link_input;
    if (srst || txc_reg[TXC_SRC] || ext_reg != ext_link_input)
      pass_cnt_reg <= 3'd0;
    else if (pass_cnt_reg != 3'd7)
      pass_cnt_reg <= pass_cnt_reg + 3'd1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_clr_rx; rd_rxi ##1 rd_rxi |=> reg_rdata[7:4] == 4'h0; endproperty
  a_clr_rx: assert property (p_clr_rx) else $error("rx flags stay after read");
  property p_clr_tx; rd_txi ##1 rd_txi |=> !reg_rdata[TXI_STARVE]; endproperty
  a_clr_tx: assert property (p_clr_tx) else $error("underrun stays after read");
  property p_pair; rd_txi |=> !(reg_rdata[TXI_EMPTY] && reg_rdata[TXI_FULL]); endproperty
  a_pair: assert property (p_pair) else $error("tx empty and full at once");
  property p_spare; rd_txi |=> reg_rdata[7:3] == 5'h00; endproperty
  a_spare: assert property (p_spare) else $error("tx info spare bits set");
  property p_head; rd_rxi |=> !reg_rdata[RXI_POK] || reg_rdata[RXI_CLOSE]; endproperty
  a_head: assert property (p_head) else $error("good head byte not closing");
  property p_half; rd_rxi |=> !(reg_rdata[RXI_EMPTY] && $past(rx_half_full)); endproperty
  a_half: assert property (p_half) else $error("half full while empty");
  property p_ctl; rd_txc |=> reg_rdata == $past(txc_reg); endproperty
  a_ctl: assert property (p_ctl) else $error("code control readback");
  property p_pin; pass_cnt_reg == 3'd7 |-> tx_link_data == ext_reg; endproperty
  a_pin: assert property (p_pin) else $error("pin source not on line");
endmodule // hblc_link_ctrl_sva
bind hblc_link_ctrl hblc_link_ctrl_sva u_sva (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .rx_link_data, .ext_link_input, .tx_link_data, .rx_half_full);

// >>> verif/tb.sv
// self-checking bench for the packet and code link controller
`timescale 1ns/1ps
module tb import hblc_pkg::*;;
  // ==========================================================
  // signals and instances
  logic sys_clk, srst, reg_wr, reg_rd, ext_link_input, flip, rx_link_data, tx_link_data;
  logic rx_half_full;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, x, y;
  logic [7:0] pk [5];
  logic [15:0] fcs;
  logic [63:0] line_sr;
  logic line_hit = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  hblc_link_ctrl #(.RX_DEPTH(8), .TX_DEPTH(8), .BIT_DIV(4), .CODE_VERIFY(3)) uut (.sys_clk,
    .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_link_data,
    .ext_link_input, .tx_link_data, .rx_half_full);
  hblc_far_end far (.sys_clk, .srst, .tx_link_data, .flip, .rx_link_data);
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // one bus cycle; q takes the read data standing in the cycle just ended
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    q = reg_rdata;
  endtask
  task automatic pause(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    pause(1);
    d = q;
  endtask
  // two reads with no gap
  task automatic rd2(input logic [7:0] a, output logic [7:0] d1, output logic [7:0] d2);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b1, a, 8'h00);
    d1 = q;
    pause(1);
    d2 = q;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g,
    input logic [7:0] m);
    num_checks++;
    if ((g & m) !== (e & m))
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e & m, g & m);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
    input string n);
    rd(a, x);
    chk(n, e, x, m);
  endtask
  // read until a bit is high, bounded
  task automatic poll(input logic [7:0] a, input int b);
    for (int i = 0; i < 400; i++)
    begin
      rd(a, x);
      if (x[b] === 1'b1)
        return;
    end
    chk("poll", 8'h01, x >> b, 8'h01);
  endtask
  // empty the receive queue
  task automatic drain;
    for (int i = 0; i < 80; i++)
    begin
      rd(ADDR_RX_INFO, x);
      if (x[RXI_EMPTY] === 1'b1)
        return;
      rd(ADDR_RX_FIFO, y);
    end
  endtask
  task automatic fill(input int n, input logic last);
    for (int i = 0; i < n; i++)
      wr((last && i == n - 1) ? ADDR_TX_LAST : ADDR_TX_FIFO, 8'h00);
    pause(1);
  endtask
  // frame check over one byte, first bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int k = 0; k < 8; k++)
      c = (c[0] ^ b[k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one code pattern on the line, four clocks a bit, first bit in the low end
  function automatic logic [63:0] code_shape(input logic [5:0] c);
    logic [15:0] p;
    logic [63:0] s;
    p = {1'b0, c, 1'b0, ONES_BYTE};
    for (int k = 0; k < 64; k++)
      s[k] = p[k / 4];
    return s;
  endfunction
  // watch the outgoing line for the code pattern sent below
  always @(posedge sys_clk)
  begin
    line_sr <= {tx_link_data, line_sr[63:1]};
    if (line_sr == code_shape(6'h1A))
      line_hit <= 1'b1;
  end
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    srst = 1'b1;
    {reg_wr, reg_rd, ext_link_input, flip} = 4'b0010;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rchk(ADDR_RX_CODE, 8'h3F, 8'hFF, "code reset");
    wr(ADDR_TX_CODE, 8'h40);
    pause(100);
    rd2(ADDR_RX_INFO, x, y);
    rchk(ADDR_RX_INFO, 8'h08, 8'hF8, "rx info");
    rchk(ADDR_TX_INFO, 8'h04, 8'h07, "tx info");
    rchk(ADDR_TX_CODE, 8'h40, 8'hFF, "code ctl");
    rchk(ADDR_RX_FIFO, 8'h00, 8'hFF, "empty read");
    rchk(8'h20, 8'h00, 8'hFF, "unmapped");
    // queue without end mark, let it run dry
    fill(9, 1'b0);
    rchk(ADDR_TX_INFO, 8'h02, 8'h07, "tx full");
    poll(ADDR_TX_INFO, TXI_STARVE);
    chk("underrun", 8'h05, x, 8'h07);
    rd2(ADDR_TX_INFO, x, y);
    chk("underrun clear", 8'h04, x, 8'h07);
    pause(100);
    rd2(ADDR_RX_INFO, x, y);
    chk("abort", 8'h80, x, 8'h80);
    chk("abort clear", 8'h00, y, 8'hF0);
    drain;
    // clean packet with end mark
    fcs = ~crc_step(crc_step(crc_step(CRC_INIT, 8'hAA), 8'hC3), 8'h55);
    pk = '{8'hAA, 8'hC3, 8'h55, fcs[7:0], fcs[15:8]};
    wr(ADDR_TX_FIFO, 8'hAA);
    wr(ADDR_TX_FIFO, 8'hC3);
    wr(ADDR_TX_LAST, 8'h55);
    pause(400);
    chk("half full", 8'h01, {7'h00, rx_half_full}, 8'h01);
    for (int i = 0; i < 5; i++)
    begin
      rchk(ADDR_RX_INFO, {3'b000, i == 0, 1'b0, i == 4, i == 4, i == 0}, 8'hFF, "head");
      rchk(ADDR_RX_FIFO, pk[i], 8'hFF, "byte");
    end
    rchk(ADDR_RX_INFO, 8'h08, 8'h08, "drained");
    chk("half clear", 8'h00, {7'h00, rx_half_full}, 8'h01);
    // one line bit corrupted inside the packet
    fill(5, 1'b1);
    pause(100);
    flip <= 1'b1;
    pause(4);
    flip <= 1'b0;
    pause(300);
    rchk(ADDR_RX_INFO, 8'h40, 8'h50, "check error");
    drain;
    // packet longer than the receive queue
    fill(8, 1'b1);
    pause(500);
    rchk(ADDR_RX_INFO, 8'h20, 8'h30, "overflow");
    drain;
    // send a code, then stop it
    wr(ADDR_TX_CODE, 8'hDA);
    pause(800);
    rd2(ADDR_RX_CODE, x, y);
    chk("code seen", 8'hDA, x, 8'hFF);
    chk("code latch clear", 8'h5A, y, 8'hFF);
    chk("line code", 8'h01, {7'h00, line_hit}, 8'h01);
    wr(ADDR_TX_CODE, 8'h5A);
    pause(300);
    rchk(ADDR_RX_CODE, 8'h1A, 8'hFF, "code held");
    rd2(ADDR_RX_INFO, x, y);
    drain;
    // line taken from the pin
    wr(ADDR_TX_CODE, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      ext_link_input <= i[0];
      pause(8);
      chk("pin path", {7'h00, i[0]}, {7'h00, tx_link_data}, 8'h01);
    end
    end_sim;
  end
endmodule // tb
